// File: logic/motion_guard_pkg.sv
`default_nettype none
package motion_guard_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] PPR_OFS        = 8'h04;
  localparam logic [7:0] BRK_REL_OFS    = 8'h08;
  localparam logic [7:0] DEENERGIZE_OFS = 8'h0c;
  localparam logic [7:0] BRK_SPEED_OFS  = 8'h10;
  localparam logic [7:0] BRK_WAIT_OFS   = 8'h14;
  localparam logic [7:0] ST_UPPER_OFS   = 8'h18;
  localparam logic [7:0] MT_UPPER_OFS   = 8'h1c;
  localparam logic [7:0] ST_LOWER_OFS   = 8'h20;
  localparam logic [7:0] MT_LOWER_OFS   = 8'h24;
  localparam logic [7:0] STATUS_OFS     = 8'h28;
  localparam logic [7:0] MASK_OFS       = 8'h2c;
  localparam logic [7:0] STATE_OFS      = 8'h30;
  // Control register fields
  localparam int CTRL_DIR_BIT    = 0;
  localparam int CTRL_POL_BIT    = 1;
  localparam int CTRL_SOFT_LSB   = 2;
  localparam int CTRL_ENC_BIT    = 4;
  localparam int CTRL_SON_BIT    = 5;
  localparam int CTRL_TEACH_UP   = 8;
  localparam int CTRL_TEACH_LO   = 9;
  // Status / mask event bits
  localparam int EV_ALARM_STOP   = 0;
  localparam int EV_FWD_STOP     = 1;
  localparam int EV_REV_STOP     = 2;
  localparam int EV_SOFT_HIT     = 3;
  localparam int EV_BITS         = 4;
  // Reset values, then the soft-limit select and encoder type codes
  localparam logic [31:0] PPR_RST        = 32'h0000_09c4;
  localparam logic [31:0] DELAY_RST      = 32'h0000_0000;
  localparam logic [15:0] BRK_SPEED_RST  = 16'h0064;
  localparam logic [31:0] ST_BOUND_RST   = 32'h0000_0000;
  localparam logic [15:0] MT_UPPER_RST   = 16'h7fff;
  localparam logic [15:0] MT_LOWER_RST   = 16'h8000;
  localparam logic [1:0]  SOFT_SEL_ON    = 2'h1;
  localparam logic        ENC_ABSOLUTE   = 1'h1;
  // Timing: delay registers count in ticks of this length
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_NS         = 1000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {ST_OFF, ST_RELEASE, ST_RUN, ST_STOP_HOLD, ST_ALARM} brake_state_e;
endpackage
`default_nettype wire

// File: logic/servo_motion_io_guard.sv
// Notes on behaviour
// - Direction select reverses motor turning for the same command polarity.
// - Divided output is an A/B quadrature pair, pulses per rev programmable.
// - Polarity 0: forward gives A leading B by 90 deg; 1 inverts.
// - Direction select changes neither quadrature pattern nor monitor sign.
// - Servo-on releases brake, then waits a programmable delay before energising.
// - Normal stop drops brake with enable; motor stays energised a programmable delay.
// - Alarm while turning stops motor; brake drops on speed threshold or wait.
// - Forward inhibit input, while active, refuses forward rotation.
// - Reverse inhibit input, while active, refuses reverse rotation.
// - Limit hit while moving toward it stops at once until released.
// - Soft-limit select takes 0 to 2, default 0; only value 1 enables checking.
// - Soft bounds: 32-bit single-turn and 16-bit multi-turn, settable or taught.
// - Soft limits act only with absolute encoder and select equal to 1.
// - Larger bound is positive limit, smaller is negative limit.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module servo_motion_io_guard #(
  parameter int ENC_COUNTS_PER_REV = 131072
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        forward_inhibit_in,
  input  wire logic        reverse_inhibit_in,
  input  wire logic        alarm_in,
  input  wire logic signed [15:0] speed_cmd_in,
  input  wire logic signed [15:0] motor_speed_in,
  input  wire logic        enc_step_in,
  input  wire logic        enc_dir_in,
  input  wire logic [31:0] abs_single_turn_in,
  input  wire logic [15:0] abs_multi_turn_in,
  output logic signed [15:0] motor_cmd_out,
  output logic             energize_out,
  output logic             brake_release_out,
  output logic             phase_a_out,
  output logic             phase_b_out,
  output logic             irq
);
  import motion_guard_pkg::*;

  // Software-held configuration and sticky event status
  logic        rotation_direction_select_q;
  logic        output_phase_polarity_q;
  logic [1:0]  soft_limit_select_q;
  logic        encoder_type_select_q;
  logic        servo_on_q;
  logic [31:0] output_pulses_per_rev_q;
  logic [31:0] brake_release_delay_q;
  logic [31:0] deenergize_delay_q;
  logic [15:0] brake_speed_threshold_q;
  logic [31:0] servo_off_brake_wait_q;
  logic [31:0] single_turn_upper_bound_q;
  logic [15:0] multi_turn_upper_bound_q;
  logic [31:0] single_turn_lower_bound_q;
  logic [15:0] multi_turn_lower_bound_q;
  logic [EV_BITS-1:0] status_q;
  logic [EV_BITS-1:0] mask_q;

  // Bus data-phase bookkeeping
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        addr_phase;
  logic        rd_status;

  assign addr_phase = hsel && hready && htrans[1];
  assign rd_status  = addr_phase && !hwrite && (haddr[7:0] == STATUS_OFS);

  // Zero-wait slave; response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_q <= haddr[7:0];
    end
  end

  // Three-stage pin synchronisers; filtered level moves when stages 2 and 3 agree
  logic [2:0] fwd_s_q, rev_s_q, alm_s_q;
  logic       fwd_inh_q, rev_inh_q, alarm_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_s_q   <= 3'h0;
      rev_s_q   <= 3'h0;
      alm_s_q   <= 3'h0;
      fwd_inh_q <= 1'b0;
      rev_inh_q <= 1'b0;
      alarm_q   <= 1'b0;
    end else begin
      fwd_s_q <= {fwd_s_q[1:0], forward_inhibit_in};
      rev_s_q <= {rev_s_q[1:0], reverse_inhibit_in};
      alm_s_q <= {alm_s_q[1:0], alarm_in};
      if (fwd_s_q[1] == fwd_s_q[2]) fwd_inh_q <= fwd_s_q[2];
      if (rev_s_q[1] == rev_s_q[2]) rev_inh_q <= rev_s_q[2];
      if (alm_s_q[1] == alm_s_q[2]) alarm_q <= alm_s_q[2];
    end
  end

  // Soft limits on the combined 48-bit position
  logic signed [47:0] abs_pos, bound_a, bound_b, pos_limit, neg_limit;
  logic               soft_active, soft_fwd_block, soft_rev_block;
  assign abs_pos     = {abs_multi_turn_in, abs_single_turn_in};
  assign bound_a     = {multi_turn_upper_bound_q, single_turn_upper_bound_q};
  assign bound_b     = {multi_turn_lower_bound_q, single_turn_lower_bound_q};
  assign pos_limit   = (bound_a > bound_b) ? bound_a : bound_b;
  assign neg_limit   = (bound_a > bound_b) ? bound_b : bound_a;
  assign soft_active = (encoder_type_select_q == ENC_ABSOLUTE)
                       && (soft_limit_select_q == SOFT_SEL_ON);
  assign soft_fwd_block = soft_active && (abs_pos >= pos_limit);
  assign soft_rev_block = soft_active && (abs_pos <= neg_limit);

  // Motion permits; both blocks together leave no direction open
  logic fwd_block, rev_block, cmd_fwd, cmd_rev, fwd_hit, rev_hit;
  assign fwd_block = fwd_inh_q || soft_fwd_block;
  assign rev_block = rev_inh_q || soft_rev_block;
  assign cmd_fwd   = !speed_cmd_in[15] && (speed_cmd_in != 16'sh0000);
  assign cmd_rev   = speed_cmd_in[15];
  assign fwd_hit   = fwd_block && cmd_fwd;
  assign rev_hit   = rev_block && cmd_rev;

  // One enable pulse per delay tick
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick;
  assign tick = (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // Brake and energise sequencing
  brake_state_e state_q;
  logic [31:0]  wait_q;
  logic [15:0]  speed_abs;
  logic         alarm_ev;
  assign speed_abs = motor_speed_in[15] ? 16'(-motor_speed_in) : motor_speed_in;
  assign alarm_ev  = alarm_q && (state_q != ST_OFF) && (state_q != ST_ALARM);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q           <= ST_OFF;
      wait_q            <= 32'h0;
      energize_out      <= 1'b0;
      brake_release_out <= 1'b0;
    end else begin
      if (tick) wait_q <= wait_q + 32'h1;
      case (state_q)
        ST_OFF: begin
          if (servo_on_q && !alarm_q) begin
            state_q           <= ST_RELEASE;
            brake_release_out <= 1'b1;
            wait_q            <= 32'h0;
          end
        end
        ST_RELEASE: begin
          if (alarm_q) begin
            state_q           <= ST_OFF;
            brake_release_out <= 1'b0;
          end else if (!servo_on_q) begin
            state_q           <= ST_OFF;
            brake_release_out <= 1'b0;
          end else if (wait_q >= brake_release_delay_q) begin
            state_q      <= ST_RUN;
            energize_out <= 1'b1;
          end
        end
        ST_RUN: begin
          if (alarm_q) begin
            state_q      <= ST_ALARM;
            energize_out <= 1'b0;
            wait_q       <= 32'h0;
          end else if (!servo_on_q) begin
            state_q           <= ST_STOP_HOLD;
            brake_release_out <= 1'b0;
            wait_q            <= 32'h0;
          end
        end
        ST_STOP_HOLD: begin
          if (alarm_q || wait_q >= deenergize_delay_q) begin
            state_q      <= ST_OFF;
            energize_out <= 1'b0;
          end
        end
        ST_ALARM: begin
          // Brake open until shaft slows or wait expires
          if (speed_abs < brake_speed_threshold_q || wait_q >= servo_off_brake_wait_q) begin
            state_q           <= ST_OFF;
            brake_release_out <= 1'b0;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Blocked or idle states command zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_cmd_out <= 16'sh0000;
    end else if (state_q != ST_RUN || alarm_q || fwd_hit || rev_hit) begin
      motor_cmd_out <= 16'sh0000;
    end else if (rotation_direction_select_q) begin
      motor_cmd_out <= 16'(-speed_cmd_in);
    end else begin
      motor_cmd_out <= speed_cmd_in;
    end
  end

  // Quadrature divider; logical direction undoes the direction select
  logic        logic_fwd;
  logic [31:0] acc_q;
  logic [32:0] acc_sum;
  logic        qstep;
  logic [1:0]  quad_q;
  assign logic_fwd = enc_dir_in ^ rotation_direction_select_q;
  assign acc_sum   = {1'b0, acc_q} + {1'b0, output_pulses_per_rev_q[29:0], 2'b00};
  assign qstep     = enc_step_in && (acc_sum >= 33'(ENC_COUNTS_PER_REV));
  // Fractional accumulator spreads edges evenly, at most one per encoder count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 32'h0;
    end else if (enc_step_in) begin
      acc_q <= qstep ? 32'(acc_sum - 33'(ENC_COUNTS_PER_REV)) : acc_sum[31:0];
    end
  end

  // Binary step counter; decoded AB outputs change one bit per edge, so no glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quad_q <= 2'h0;
    end else if (qstep) begin
      if (logic_fwd ^ output_phase_polarity_q) begin
        quad_q <= quad_q + 2'h1;
      end else begin
        quad_q <= quad_q - 2'h1;
      end
    end
  end

  // Up count 0,1,2,3 maps to AB 00,10,11,01: A leads B
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_a_out <= 1'b0;
      phase_b_out <= 1'b0;
    end else begin
      phase_a_out <= quad_q[1] ^ quad_q[0];
      phase_b_out <= quad_q[1];
    end
  end

  // Register writes; teach bits are write-only strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rotation_direction_select_q <= 1'b0;
      output_phase_polarity_q     <= 1'b0;
      soft_limit_select_q         <= 2'h0;
      encoder_type_select_q       <= 1'b0;
      servo_on_q                  <= 1'b0;
      output_pulses_per_rev_q     <= PPR_RST;
      brake_release_delay_q       <= DELAY_RST;
      deenergize_delay_q          <= DELAY_RST;
      brake_speed_threshold_q     <= BRK_SPEED_RST;
      servo_off_brake_wait_q      <= DELAY_RST;
      single_turn_upper_bound_q   <= ST_BOUND_RST;
      multi_turn_upper_bound_q    <= MT_UPPER_RST;
      single_turn_lower_bound_q   <= ST_BOUND_RST;
      multi_turn_lower_bound_q    <= MT_LOWER_RST;
      mask_q                      <= '0;
    end else if (wr_pend_q) begin
      if (wr_addr_q == CTRL_OFS) begin
        rotation_direction_select_q <= hwdata[CTRL_DIR_BIT];
        output_phase_polarity_q     <= hwdata[CTRL_POL_BIT];
        // Select value 3 is outside the legal range and is refused
        if (hwdata[CTRL_SOFT_LSB+:2] != 2'h3) soft_limit_select_q <= hwdata[CTRL_SOFT_LSB+:2];
        encoder_type_select_q <= hwdata[CTRL_ENC_BIT];
        servo_on_q            <= hwdata[CTRL_SON_BIT];
        if (hwdata[CTRL_TEACH_UP]) begin
          single_turn_upper_bound_q <= abs_single_turn_in;
          multi_turn_upper_bound_q  <= abs_multi_turn_in;
        end
        if (hwdata[CTRL_TEACH_LO]) begin
          single_turn_lower_bound_q <= abs_single_turn_in;
          multi_turn_lower_bound_q  <= abs_multi_turn_in;
        end
      end else if (wr_addr_q == PPR_OFS) begin
        output_pulses_per_rev_q <= hwdata;
      end else if (wr_addr_q == BRK_REL_OFS) begin
        brake_release_delay_q <= hwdata;
      end else if (wr_addr_q == DEENERGIZE_OFS) begin
        deenergize_delay_q <= hwdata;
      end else if (wr_addr_q == BRK_SPEED_OFS) begin
        brake_speed_threshold_q <= hwdata[15:0];
      end else if (wr_addr_q == BRK_WAIT_OFS) begin
        servo_off_brake_wait_q <= hwdata;
      end else if (wr_addr_q == ST_UPPER_OFS) begin
        single_turn_upper_bound_q <= hwdata;
      end else if (wr_addr_q == MT_UPPER_OFS) begin
        multi_turn_upper_bound_q <= hwdata[15:0];
      end else if (wr_addr_q == ST_LOWER_OFS) begin
        single_turn_lower_bound_q <= hwdata;
      end else if (wr_addr_q == MT_LOWER_OFS) begin
        multi_turn_lower_bound_q <= hwdata[15:0];
      end else if (wr_addr_q == MASK_OFS) begin
        mask_q <= hwdata[EV_BITS-1:0];
      end
    end
  end

  // Sticky events; a new event wins over the clear-on-read
  logic [EV_BITS-1:0] ev;
  logic               hit_fwd_q, hit_rev_q, soft_q;
  always_comb begin
    ev                = '0;
    ev[EV_ALARM_STOP] = alarm_ev;
    ev[EV_FWD_STOP]   = fwd_hit && !hit_fwd_q;
    ev[EV_REV_STOP]   = rev_hit && !hit_rev_q;
    ev[EV_SOFT_HIT]   = (soft_fwd_block || soft_rev_block) && !soft_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q  <= '0;
      hit_fwd_q <= 1'b0;
      hit_rev_q <= 1'b0;
      soft_q    <= 1'b0;
    end else begin
      status_q  <= (rd_status ? '0 : status_q) | ev;
      hit_fwd_q <= fwd_hit;
      hit_rev_q <= rev_hit;
      soft_q    <= soft_fwd_block || soft_rev_block;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_status ? '0 : status_q) | ev) & mask_q);
    end
  end

  // Read data is loaded at the address-phase edge
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    if (haddr[7:0] == CTRL_OFS) begin
      rd_d[CTRL_DIR_BIT]         = rotation_direction_select_q;
      rd_d[CTRL_POL_BIT]         = output_phase_polarity_q;
      rd_d[CTRL_SOFT_LSB+:2]     = soft_limit_select_q;
      rd_d[CTRL_ENC_BIT]         = encoder_type_select_q;
      rd_d[CTRL_SON_BIT]         = servo_on_q;
    end else if (haddr[7:0] == PPR_OFS) begin
      rd_d = output_pulses_per_rev_q;
    end else if (haddr[7:0] == BRK_REL_OFS) begin
      rd_d = brake_release_delay_q;
    end else if (haddr[7:0] == DEENERGIZE_OFS) begin
      rd_d = deenergize_delay_q;
    end else if (haddr[7:0] == BRK_SPEED_OFS) begin
      rd_d[15:0] = brake_speed_threshold_q;
    end else if (haddr[7:0] == BRK_WAIT_OFS) begin
      rd_d = servo_off_brake_wait_q;
    end else if (haddr[7:0] == ST_UPPER_OFS) begin
      rd_d = single_turn_upper_bound_q;
    end else if (haddr[7:0] == MT_UPPER_OFS) begin
      rd_d[15:0] = multi_turn_upper_bound_q;
    end else if (haddr[7:0] == ST_LOWER_OFS) begin
      rd_d = single_turn_lower_bound_q;
    end else if (haddr[7:0] == MT_LOWER_OFS) begin
      rd_d[15:0] = multi_turn_lower_bound_q;
    end else if (haddr[7:0] == STATUS_OFS) begin
      rd_d[EV_BITS-1:0] = status_q;
    end else if (haddr[7:0] == MASK_OFS) begin
      rd_d[EV_BITS-1:0] = mask_q;
    end else if (haddr[7:0] == STATE_OFS) begin
      rd_d = {20'h0, soft_rev_block, soft_fwd_block, rev_inh_q, fwd_inh_q,
              alarm_q, energize_out, brake_release_out, 2'h0, 3'(state_q)};
    end
    if (haddr[31:8] != 24'h000000) rd_d = 32'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_d;
    end
  end
endmodule
`default_nettype wire

// File: test/motion_guard_chk.sv
`timescale 1ns/100ps
`default_nettype none
module motion_guard_chk (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               forward_inhibit_in,
  input wire logic               reverse_inhibit_in,
  input wire logic               alarm_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic               enc_step_in,
  input wire logic signed [15:0] motor_cmd_out,
  input wire logic               energize_out,
  input wire logic               brake_release_out,
  input wire logic               phase_a_out,
  input wire logic               phase_b_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Six samples span synchroniser and output register
  sequence fwd_held; forward_inhibit_in [*6]; endsequence
  sequence rev_held; reverse_inhibit_in [*6]; endsequence
  sequence alarm_held; alarm_in [*6]; endsequence
  a_brake_first: assert property ($rose(brake_release_out) |-> !energize_out)
    else $error("live at release");
  a_energy_after_brake: assert property ($rose(energize_out) |-> $past(brake_release_out))
    else $error("brake not open");
  a_drive_needs_energy: assert property (motor_cmd_out != 16'sh0 |-> energize_out)
    else $error("drive unpowered");
  a_fwd_refused: assert property (fwd_held ##0 $past(speed_cmd_in) > 16'sh0 |-> motor_cmd_out == 16'sh0)
    else $error("forward drive");
  a_rev_refused: assert property (rev_held ##0 $past(speed_cmd_in) < 16'sh0 |-> motor_cmd_out == 16'sh0)
    else $error("reverse drive");
  a_both_refused: assert property ((fwd_held and rev_held) |-> motor_cmd_out == 16'sh0)
    else $error("motion with both inhibits");
  a_alarm_stops: assert property (alarm_held |-> motor_cmd_out == 16'sh0 && !energize_out)
    else $error("driven in alarm");
  a_quad_one_bit: assert property (!($changed(phase_a_out) && $changed(phase_b_out)))
    else $error("both phases moved together");
  a_quad_after_step: assert property ($changed({phase_a_out, phase_b_out}) |-> $past(enc_step_in, 2))
    else $error("edge without count");
endmodule
bind servo_motion_io_guard motion_guard_chk chk_i (.*);
`default_nettype wire

// File: test/motion_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module motion_far_side (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic signed [15:0] motor_cmd_out,
  input  wire logic               energize_out,
  output logic signed [15:0]      motor_speed_in,
  output logic                    enc_step_in,
  output logic                    enc_dir_in,
  output logic [31:0]             abs_single_turn_in,
  output logic [15:0]             abs_multi_turn_in
);
  logic signed [47:0] pos_q;
  logic [10:0]        acc_q;
  logic [15:0]        mag;
  logic [11:0]        sum;
  // Speeds above 2047 would alias
  assign mag = motor_speed_in < 16'sh0 ? -motor_speed_in : motor_speed_in;
  assign sum = {1'b0, acc_q} + {1'b0, mag[10:0]};
  assign abs_single_turn_in = pos_q[31:0];
  assign abs_multi_turn_in = pos_q[47:32];
  // Shaft coasts when de-energised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_speed_in <= 16'sh0;
    end else begin
      motor_speed_in <= energize_out ? motor_cmd_out : motor_speed_in / 16'sh2;
    end
  end
  // Encoder counts; speed sign is physical direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 11'h0;
      enc_step_in <= 1'h0;
      enc_dir_in <= 1'h0;
      pos_q <= 48'sh0;
    end else begin
      acc_q <= sum[10:0];
      enc_step_in <= sum[11];
      enc_dir_in <= motor_speed_in > 16'sh0;
      if (sum[11]) pos_q <= pos_q + (motor_speed_in > 16'sh0 ? 48'sh1 : -48'sh1);
    end
  end
endmodule
`default_nettype wire

// File: test/servo_motion_io_guard_test.sv
`timescale 1ns/100ps
`default_nettype none
module servo_motion_io_guard_test;
  import motion_guard_pkg::*;
  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, up_exp, watch;
  logic [31:0]        haddr, hwdata, hrdata, abs_single_turn_in, q;
  logic [1:0]         htrans, ab_q;
  logic [2:0]         hsize;
  logic               forward_inhibit_in, reverse_inhibit_in, alarm_in, enc_step_in, enc_dir_in;
  logic signed [15:0] speed_cmd_in, motor_speed_in, motor_cmd_out, mag;
  logic [15:0]        abs_multi_turn_in;
  logic               energize_out, brake_release_out, phase_a_out, phase_b_out;
  logic signed [47:0] p, hi, lo;
  int                 bad_count, total_checks, steps, edges, seed, n;
  // One count gives one output edge at 16 pulses
  servo_motion_io_guard #(.ENC_COUNTS_PER_REV(64)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .forward_inhibit_in, .reverse_inhibit_in, .alarm_in,
    .speed_cmd_in, .motor_speed_in, .enc_step_in, .enc_dir_in, .abs_single_turn_in,
    .abs_multi_turn_in, .motor_cmd_out, .energize_out, .brake_release_out, .phase_a_out,
    .phase_b_out, .irq);
  motion_far_side far (.hclk, .hresetn, .motor_cmd_out, .energize_out, .motor_speed_in,
    .enc_step_in, .enc_dir_in, .abs_single_turn_in, .abs_multi_turn_in);
  always #2.5 hclk = ~hclk;
  function automatic logic [1:0] nxt(input logic [1:0] ab, input logic up);
    return up ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
  endfunction
  function automatic logic [31:0] rst_exp(input int i);
    case (i)
      1: return 32'h9c4;
      4: return 32'h64;
      7: return 32'h7fff;
      9: return 32'h8000;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Single word transfer; read data in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 1'h0);
  endtask
  // Wait for energise (0) or brake (1) to reach v
  task automatic wt(input int sel, input logic v, input int lim);
    n = 0;
    while ((sel ? brake_release_out : energize_out) !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(n < lim, 1'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Quadrature order watch
  always @(posedge hclk) begin
    if (watch && enc_step_in) steps++;
    if (watch && {phase_a_out, phase_b_out} !== ab_q) begin
      edges++;
      chk(phase_a_out ^ phase_b_out ^ ab_q[1] ^ ab_q[0], 1'h1);
      chk({phase_a_out, phase_b_out}, nxt(ab_q, up_exp));
    end
    ab_q <= {phase_a_out, phase_b_out};
  end
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
  initial begin
    seed = 66739;
    hclk = 0;
    {hresetn, hsel, hwrite, watch, up_exp, forward_inhibit_in, reverse_inhibit_in} = 0;
    {haddr, hwdata, htrans, ab_q, alarm_in, speed_cmd_in} = 0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 14; i++) begin
      bus(1'h0, 8'(i * 4), 32'h0);
      chk(q, rst_exp(i));
    end
    bus(1'h1, 8'h40, 32'hffffffff);
    bus(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, CTRL_OFS, 32'hc);
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, CTRL_OFS, 32'h8);
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h8);
    bus(1'h1, PPR_OFS, 32'h10);
    bus(1'h1, BRK_REL_OFS, 32'h2);
    bus(1'h1, DEENERGIZE_OFS, 32'h2);
    bus(1'h1, BRK_WAIT_OFS, 32'h2);
    bus(1'h1, CTRL_OFS, 32'h20);
    wt(1, 1'h1, 10);
    chk(energize_out, 1'h0);
    wt(0, 1'h1, 700);
    chk(n > 190, 1'h1);
    // All direction, polarity, sign cases
    for (int k = 0; k < 8; k++) begin
      bus(1'h1, CTRL_OFS, 32'h20 | k[1:0]);
      {steps, edges} = 0;
      up_exp = k[2] ^ k[1];
      watch = 1'h1;
      mag = 16'(($random(seed) & 32'h1ff) + 1);
      speed_cmd_in <= k[2] ? mag : -mag;
      repeat (3) @(posedge hclk);
      chk(motor_cmd_out, k[0] ? -speed_cmd_in : speed_cmd_in);
      repeat (150) @(posedge hclk);
      speed_cmd_in <= 16'sh0;
      repeat (20) @(posedge hclk);
      watch = 1'h0;
      chk(edges, steps);
    end
    bus(1'h1, CTRL_OFS, 32'h20);
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, MASK_OFS, s ? 32'h0 : 32'h6);
      speed_cmd_in <= s ? -16'sh12c : 16'sh12c;
      forward_inhibit_in <= s == 0;
      reverse_inhibit_in <= s == 1;
      repeat (8) @(posedge hclk);
      chk(motor_cmd_out, 32'h0);
      chk(irq, s == 0);
      speed_cmd_in <= s ? 16'sh12c : -16'sh12c;
      repeat (3) @(posedge hclk);
      chk(motor_cmd_out, s ? 16'sh12c : -16'sh12c);
      forward_inhibit_in <= 1'h1;
      reverse_inhibit_in <= 1'h1;
      repeat (8) @(posedge hclk);
      chk(motor_cmd_out, 32'h0);
      {forward_inhibit_in, reverse_inhibit_in, speed_cmd_in} <= 0;
      repeat (8) @(posedge hclk);
      bus(1'h0, STATUS_OFS, 32'h0);
      chk(q & 32'h6, 32'h6);
      repeat (3) @(posedge hclk);
      chk(irq, 1'h0);
    end
    repeat (10) @(posedge hclk);
    bus(1'h1, CTRL_OFS, 32'h0); // Enable withdrawn only at standstill
    wt(1, 1'h0, 10);
    chk(energize_out, 1'h1);
    wt(0, 1'h0, 700);
    chk(n > 190, 1'h1);
    // Threshold path, then timed path
    for (int t = 0; t < 2; t++) begin
      bus(1'h1, BRK_SPEED_OFS, t ? 32'h0 : 32'h64);
      bus(1'h1, CTRL_OFS, 32'h20);
      wt(0, 1'h1, 700);
      speed_cmd_in <= 16'sh1f4;
      repeat (5) @(posedge hclk);
      alarm_in <= 1'h1;
      repeat (7) @(posedge hclk);
      chk(energize_out, 1'h0);
      wt(1, 1'h0, 700);
      chk(n < 50, t == 0);
      bus(1'h0, STATUS_OFS, 32'h0);
      chk(q[0], 1'h1);
      alarm_in <= 1'h0;
      speed_cmd_in <= 16'sh0;
      bus(1'h1, CTRL_OFS, 32'h0);
      repeat (700) @(posedge hclk);
    end
    bus(1'h1, CTRL_OFS, 32'h20);
    wt(0, 1'h1, 700);
    p = {abs_multi_turn_in, abs_single_turn_in};
    hi = p + 48'sh14;
    lo = p - 48'sh3e8;
    bus(1'h1, ST_UPPER_OFS, lo[31:0]); // Smaller bound in the upper slot
    bus(1'h1, MT_UPPER_OFS, {16'h0, lo[47:32]});
    bus(1'h1, ST_LOWER_OFS, hi[31:0]);
    bus(1'h1, MT_LOWER_OFS, {16'h0, hi[47:32]});
    for (int c = 0; c < 4; c++) begin
      bus(1'h1, CTRL_OFS, c == 1 ? 32'h38 : (c == 2 ? 32'h24 : 32'h34));
      speed_cmd_in <= c == 3 ? -16'sh12c : 16'sh12c;
      repeat (200) @(posedge hclk);
      chk(motor_cmd_out, c ? speed_cmd_in : 16'sh0);
    end
    bus(1'h0, STATUS_OFS, 32'h0);
    chk(q[3], 1'h1);
    test_done();
  end
endmodule
`default_nettype wire
